// File: dv/mxadc_host.sv
module mxadc_host (
   // clock
   input wire ref_clk,
   // link pins to the device
   output logic sclk,
   output logic sel_cs,
   output logic conv_cs,
   // shared data wire
   output logic host_d,
   output wire host_en,
   input wire data_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cap [1:31];

   // pin turns to input whenever either select is low
   assign host_en = sel_cs && conv_cs;

   initial begin
      sclk = 1'b0;
      sel_cs = 1'b1;
      conv_cs = 1'b1;
      host_d = 1'b0;
   end

   // half of a 64 ns sclk period
   task half;
      repeat (4) @(negedge ref_clk);
   endtask

   task load(input logic [5:0] bits, input logic tied);
      integer i;
      sel_cs = 1'b1;
      for (i = 5; i >= 0; i--) begin
         host_d = bits[i];
         half;
         sclk = 1'b1;
         half;
         sclk = 1'b0;
      end
      half;
      sel_cs = 1'b0;
      conv_cs = !tied;
   endtask

   // sclk stands low outside frames
   task run(input integer pre, input integer n);
      integer k;
      if (conv_cs) begin
         conv_cs = 1'b0;
      end
      repeat (pre) @(negedge ref_clk);
      for (k = 1; k <= n; k++) begin
         half;
         cap[k] = data_wire;
         sclk = 1'b1;
         half;
         sclk = 1'b0;
      end
      half;
      conv_cs = 1'b1;
      // a select high for zero time is never seen, so the next frame would not restart
      repeat (8) @(negedge ref_clk);
   endtask
endmodule

// File: dv/mxadc_sequencer_monitor.sv
module mxadc_seq_monitor (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // link pins
   input wire sclk,
   input wire selector_chip_select,
   input wire converter_chip_select,
   // device outputs
   input wire data_out_q,
   input wire data_out_en_q,
   input wire [7:0] channel_enable_q,
   input wire sampling_q,
   input wire holding_q,
   input wire converter_power_q,
   input wire [11:0] dac_code,
   input wire result_valid_q
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [2:0] sclk_q;
   reg hold_q;
   reg rst_q;
   reg [3:0] fall_q;

   // counts seen sclk falls while in hold; the first hold cycle is skipped so the starting fall is not counted
   always @(posedge ref_clk) begin
      sclk_q <= {sclk_q[1:0], sclk};
      hold_q <= holding_q;
      rst_q <= sys_rst;
      if (!holding_q)
         fall_q <= 4'h0;
      else if (hold_q && sclk_q[2] && !sclk_q[1])
         fall_q <= fall_q + 4'h1;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   chk_conv_idle: assert property (converter_chip_select [*5] |-> !converter_power_q && !data_out_en_q)
      else $error("converter active while its select is high");
   chk_twelve_falls: assert property ($fell(holding_q) && !rst_q |-> fall_q == 4'hc)
      else $error("hold did not last twelve clock cycles");
   chk_end_power: assert property ($fell(holding_q) && !rst_q |-> !converter_power_q)
      else $error("converter still powered after conversion");
   chk_hold_power: assert property (holding_q |-> converter_power_q && !sampling_q)
      else $error("hold without power or with sampling open");
   chk_sample_end: assert property ($fell(sampling_q) && !rst_q && !converter_chip_select |-> holding_q)
      else $error("sample window closed without entering hold");
   chk_null_bit: assert property ($rose(holding_q) |-> data_out_en_q && !data_out_q)
      else $error("null bit missing at hold start");
   chk_sar_start: assert property ($rose(holding_q) |-> ##[0:2] dac_code == 12'h800)
      else $error("trial code did not start at midscale");
   chk_out_release: assert property ($fell(data_out_en_q) && !rst_q |-> $past(converter_chip_select, 3))
      else $error("data wire released while converter selected");
   chk_result_ready: assert property ($fell(holding_q) && !rst_q |-> ##[0:3] result_valid_q)
      else $error("result not flagged after conversion");
   chk_chan_onehot: assert property ($onehot0(channel_enable_q))
      else $error("more than one channel on");
   chk_chan_hold: assert property ($changed(channel_enable_q) && !rst_q |-> !$past(selector_chip_select, 5))
      else $error("channel switched while selector loading");

   cover property ($rose(holding_q));
   cover property ($rose(sampling_q));
   cover property ($changed(channel_enable_q) && channel_enable_q != 8'h00);
endmodule

bind mxadc_sequencer mxadc_seq_monitor u_mxadc_seq_monitor (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk),
   .selector_chip_select(selector_chip_select), .converter_chip_select(converter_chip_select),
   .data_out_q(data_out_q), .data_out_en_q(data_out_en_q), .channel_enable_q(channel_enable_q),
   .sampling_q(sampling_q), .holding_q(holding_q), .converter_power_q(converter_power_q),
   .dac_code(dac_code), .result_valid_q(result_valid_q)
);

// File: dv/mxadc_sequencer_test.sv
module mxadc_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk;
   logic sys_rst;
   logic wire_last_q;
   logic comp_hi;
   logic saw_smp;
   logic [11:0] vin;
   integer failures;
   integer comparisons;
   wire sclk, sel_cs, conv_cs, host_d, host_en, data_wire;
   wire data_out_q, data_out_en_q, sampling_q, holding_q, converter_power_q, result_valid_q;
   wire [7:0] channel_enable_q;
   wire [11:0] dac_code;
   wire [11:0] result_q;

   // an undriven wire shows the inverse of its last level, so a stale value never passes
   assign data_wire = data_out_en_q ? data_out_q : host_en ? host_d : !wire_last_q;
   always @(posedge ref_clk) wire_last_q <= data_wire;
   always @(negedge ref_clk) comp_hi <= (vin >= dac_code);
   always @(posedge ref_clk) if (sampling_q === 1'b1) saw_smp <= 1'b1;

   mxadc_sequencer u_mxadc_sequencer (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk),
      .selector_chip_select(sel_cs), .converter_chip_select(conv_cs), .data_in(data_wire),
      .data_out_q(data_out_q), .data_out_en_q(data_out_en_q), .channel_enable_q(channel_enable_q),
      .comp_hi(comp_hi), .sampling_q(sampling_q), .holding_q(holding_q),
      .converter_power_q(converter_power_q), .dac_code(dac_code), .result_q(result_q),
      .result_valid_q(result_valid_q)
   );
   mxadc_host u_mxadc_host (
      .ref_clk(ref_clk), .sclk(sclk), .sel_cs(sel_cs), .conv_cs(conv_cs),
      .host_d(host_d), .host_en(host_en), .data_wire(data_wire)
   );

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task check(input string name, input logic [11:0] exp, input logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task summarize;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task t_reset_state;
      check("power", 12'h000, 12'(converter_power_q));
      check("drive", 12'h000, 12'(data_out_en_q));
   endtask

   // selector only, converter parked; two stale bits lead each command
   task t_select;
      integer c;
      logic [3:0] cmd;
      logic [7:0] prev;
      for (c = 0; c < 9; c++) begin
         cmd = (c < 8) ? {1'b1, c[2:0]} : 4'h5;
         prev = channel_enable_q;
         u_mxadc_host.load({~cmd[3:2], cmd}, 1'b0);
         repeat (15) @(negedge ref_clk);
         check("chan_early", 12'(prev), 12'(channel_enable_q));
         repeat (25) @(negedge ref_clk);
         check("chan_off", 12'h000, 12'(channel_enable_q));
         repeat (30) @(negedge ref_clk);
         check("chan_on", (c < 8) ? 12'h001 << c : 12'h000, 12'(channel_enable_q));
      end
   endtask

   task t_convert(input logic [11:0] v, input logic [2:0] ch);
      integer k;
      logic [11:0] msb;
      logic [11:0] lsb;
      vin = v;
      u_mxadc_host.load({2'b00, 1'b1, ch}, 1'b1);
      u_mxadc_host.run(0, 27);
      for (k = 0; k < 12; k++) msb[11 - k] = u_mxadc_host.cap[4 + k];
      for (k = 0; k < 11; k++) lsb[k + 1] = u_mxadc_host.cap[16 + k];
      lsb[0] = msb[0];
      check("null_bit", 12'h000, 12'(u_mxadc_host.cap[3]));
      check("msb_first", v, msb);
      check("lsb_first", v, lsb);
      check("tail", 12'h000, 12'(u_mxadc_host.cap[27]));
      check("result", v, result_q);
      check("chan_conv", 12'h001 << ch, 12'(channel_enable_q));
   endtask

   // converter-only pulses with a slow start so the window opens
   task t_repeat;
      integer r;
      for (r = 0; r < 2; r++) begin
         vin = 12'h3c1 + 12'(r);
         saw_smp = 1'b0;
         u_mxadc_host.run(60, 27);
         check("sampled", 12'h001, 12'(saw_smp));
         check("result_rep", vin, result_q);
         check("chan_kept", 12'h004, 12'(channel_enable_q));
      end
   endtask

   initial begin
      sys_rst = 1'b1;
      wire_last_q = 1'b0;
      comp_hi = 1'b0;
      saw_smp = 1'b0;
      vin = 12'h000;
      failures = 0;
      comparisons = 0;
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      t_reset_state;
      t_select;
      t_convert(12'h000, 3'h0);
      t_convert(12'hfff, 3'h7);
      t_convert(12'ha5c, 3'h2);
      t_repeat;
      summarize;
   end

   // all scenarios need about 2500 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      summarize;
   end
endmodule

// File: logic/mxadc_regs.vh
`ifndef MXADC_REGS_VH
`define MXADC_REGS_VH

// ****************************************
// clock and delay timing
// ****************************************
`define MXADC_CLK_MHZ 125
`define MXADC_TURN_OFF_DELAY_NS 200
`define MXADC_TON_NS 400
// least delays, rounded up to whole ref_clk cycles
`define MXADC_TURN_OFF_DELAY_CYC ((`MXADC_TURN_OFF_DELAY_NS * `MXADC_CLK_MHZ + 999) / 1000)
`define MXADC_TON_CYC ((`MXADC_TON_NS * `MXADC_CLK_MHZ + 999) / 1000)

// ****************************************
// command word layout
// ****************************************
`define MXADC_CMD_BITS 4
`define MXADC_CMD_EN_BIT 3
`define MXADC_CMD_ADDR_MSB 2
`define MXADC_CMD_ADDR_LSB 0
`define MXADC_CMD_RESET 4'h0
`define MXADC_NUM_CH 8
`define MXADC_CH_OFF 8'h00

// ****************************************
// conversion sequence counts
// ****************************************
`define MXADC_RES_BITS 12
`define MXADC_CONV_CYCLES 12
`define MXADC_HOLD_EDGE 2
`define MXADC_DRIVE_EDGE_MAX 6
`define MXADC_SAR_FIRST 12'h800
`define MXADC_CODE_RESET 12'h000
// pin synchroniser reset levels {comp, data, conv select, sel select, sclk}: selects rest high
`define MXADC_PIN_RESET 5'h06

`endif

// File: logic/mxadc_sar.v
`include "mxadc_regs.vh"

// ****************************************
// successive approximation register
// ****************************************
module mxadc_sar (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // sequence control
   input wire start,
   input wire step,
   input wire abort,
   // comparator answer: held input at or above trial code
   input wire comp_hi,
   // trial code to the capacitor array, final result
   output reg [11:0] code_q,
   output reg done_q
);
   reg [3:0] idx_q;
   reg busy_q;

   always @(posedge ref_clk) begin
      if (sys_rst || abort) begin
         code_q <= `MXADC_CODE_RESET;
         idx_q <= 4'hb;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            code_q <= `MXADC_SAR_FIRST;
            idx_q <= 4'hb;
            busy_q <= 1'b1;
         end else if (step && busy_q) begin
            // plain binary weights give unipolar straight-binary codes
            code_q[idx_q] <= comp_hi;
            if (idx_q != 4'h0) begin
               code_q[idx_q - 4'h1] <= 1'b1;
               idx_q <= idx_q - 4'h1;
            end else begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule

// File: logic/mxadc_sequencer.v
// Behaviour
// - selector high shifts data on rising clock
// - enable bit set connects channel after turn-on
// - enable bit clear turns all channels off
// - three address bits, bit2 first, pick channel
// - result codes are unipolar straight binary
// - drive shared wire by sixth falling edge
// - selector and converter selects act independently
// - channel stays connected across converter-only pulses
// - power down converter when conversion ends
// - converter fully off while its select high
// - sample from turn-on until second falling edge
// - second falling edge enters hold, starts conversion
// - conversion lasts exactly twelve clock cycles
// - launch on falling edge, capture on rising
// - keep last four bits before select falls
// - one null bit precedes the result
// - converter select high powers down, releases output
`include "mxadc_regs.vh"

module mxadc_sequencer (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // serial pins from the host
   input wire sclk,
   input wire selector_chip_select,
   input wire converter_chip_select,
   input wire data_in,
   // shared data wire, output side
   output reg data_out_q,
   output reg data_out_en_q,
   // analog selector switches
   output reg [7:0] channel_enable_q,
   // converter analog control
   input wire comp_hi,
   output reg sampling_q,
   output reg holding_q,
   output reg converter_power_q,
   output wire [11:0] dac_code,
   // result for local observation
   output reg [11:0] result_q,
   output reg result_valid_q
);
   // ****************************************
   // constants
   // ****************************************
   localparam [15:0] TURN_OFF_DELAY_CYC = `MXADC_TURN_OFF_DELAY_CYC;
   localparam [15:0] TON_CYC = `MXADC_TON_CYC;
   localparam [4:0] HOLD_CNT = `MXADC_HOLD_EDGE - 1;
   localparam [4:0] LAST_CNT = `MXADC_HOLD_EDGE - 1 + `MXADC_CONV_CYCLES;
   localparam [3:0] NUM_CH = `MXADC_NUM_CH;

   // selector states
   localparam [3:0] S_LOAD = 4'h1;
   localparam [3:0] S_OFFWAIT = 4'h2;
   localparam [3:0] S_ONWAIT = 4'h4;
   localparam [3:0] S_KEEP = 4'h8;

   // converter states
   localparam [3:0] C_IDLE = 4'h1;
   localparam [3:0] C_SAMPLE = 4'h2;
   localparam [3:0] C_CONV = 4'h4;
   localparam [3:0] C_TAIL = 4'h8;

   // ****************************************
   // address decode
   // ****************************************
   function [7:0] chan_decode;
      input en;
      input [2:0] addr;
      begin
         chan_decode = `MXADC_CH_OFF;
         // addresses beyond the fitted channel count leave all off
         if (en && ({1'b0, addr} < NUM_CH)) begin
            chan_decode[addr] = 1'b1;
         end
      end
   endfunction

   // ****************************************
   // pin synchronisers and edge detect
   // ****************************************
   wire [4:0] pins_s;
   wire sclk_s;
   wire sel_cs_s;
   wire conv_cs_s;
   wire din_s;
   wire comp_s;
   reg sclk_prev_q;
   reg sel_cs_prev_q;
   reg conv_cs_prev_q;

   mxadc_sync #(
      .WIDTH(5),
      .RST_VAL(`MXADC_PIN_RESET)
   ) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in({comp_hi, data_in, converter_chip_select, selector_chip_select, sclk}),
      .sync_out(pins_s)
   );

   assign sclk_s = pins_s[0];
   assign sel_cs_s = pins_s[1];
   assign conv_cs_s = pins_s[2];
   assign din_s = pins_s[3];
   assign comp_s = pins_s[4];

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         sclk_prev_q <= 1'b0;
         sel_cs_prev_q <= 1'b1;
         conv_cs_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_s;
         sel_cs_prev_q <= sel_cs_s;
         conv_cs_prev_q <= conv_cs_s;
      end
   end

   // capture on rising, launch on falling
   wire sclk_rise = sclk_s & ~sclk_prev_q;
   wire sclk_fall = ~sclk_s & sclk_prev_q;
   wire sel_cs_fall = ~sel_cs_s & sel_cs_prev_q;
   wire conv_cs_fall = ~conv_cs_s & conv_cs_prev_q;

   // ****************************************
   // channel selector
   // ****************************************
   reg [3:0] sel_state_q;
   reg [3:0] sel_state_d;
   reg [3:0] cmd_q;
   reg [3:0] cmd_d;
   reg [15:0] sel_tmr_q;
   reg [15:0] sel_tmr_d;
   reg [7:0] chan_d;

   // the selector has its own select, so it ignores the converter select
   always @* begin
      sel_state_d = sel_state_q;
      cmd_d = cmd_q;
      sel_tmr_d = sel_tmr_q;
      chan_d = channel_enable_q;
      if (sel_cs_s && sclk_rise) begin
         // older bits fall off the top, so the last four win
         cmd_d = {cmd_q[2:0], din_s};
      end
      case (sel_state_q)
         S_LOAD: begin
            if (sel_cs_fall) begin
               sel_state_d = S_OFFWAIT;
               sel_tmr_d = 16'h0001;
            end
         end
         S_OFFWAIT: begin
            sel_tmr_d = sel_tmr_q + 16'h0001;
            if (sel_tmr_q >= TURN_OFF_DELAY_CYC) begin
               // break before make: everything opens first
               chan_d = `MXADC_CH_OFF;
               sel_state_d = cmd_q[`MXADC_CMD_EN_BIT] ? S_ONWAIT : S_KEEP;
            end
         end
         S_ONWAIT: begin
            sel_tmr_d = sel_tmr_q + 16'h0001;
            if (sel_tmr_q >= TON_CYC) begin
               chan_d = chan_decode(cmd_q[`MXADC_CMD_EN_BIT],
                  cmd_q[`MXADC_CMD_ADDR_MSB:`MXADC_CMD_ADDR_LSB]);
               sel_state_d = S_KEEP;
            end
         end
         S_KEEP: begin
            // channel held until the next fall, whatever the converter does
            sel_tmr_d = 16'h0000;
         end
         default: begin
            sel_state_d = S_LOAD;
         end
      endcase
      if (sel_cs_s) begin
         sel_state_d = S_LOAD;
      end
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         sel_state_q <= S_LOAD;
         cmd_q <= `MXADC_CMD_RESET;
         sel_tmr_q <= 16'h0000;
         channel_enable_q <= `MXADC_CH_OFF;
      end else begin
         sel_state_q <= sel_state_d;
         cmd_q <= cmd_d;
         sel_tmr_q <= sel_tmr_d;
         channel_enable_q <= chan_d;
      end
   end

   // ****************************************
   // converter sequencer
   // ****************************************
   reg [3:0] conv_state_q;
   reg [3:0] conv_state_d;
   reg [4:0] fall_cnt_q;
   reg [4:0] fall_cnt_d;
   reg [15:0] conv_tmr_q;
   reg [15:0] conv_tmr_d;
   reg [11:0] tail_q;
   reg [11:0] tail_d;
   reg dout_d;
   reg dout_en_d;
   reg sampling_d;
   reg holding_d;
   reg power_d;
   reg sar_start;
   reg sar_step;
   wire [11:0] sar_code;
   wire sar_done;

   mxadc_sar u_sar (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(sar_start),
      .step(sar_step),
      .abort(conv_cs_s),
      .comp_hi(comp_s),
      .code_q(sar_code),
      .done_q(sar_done)
   );

   assign dac_code = sar_code;

   always @* begin
      conv_state_d = conv_state_q;
      fall_cnt_d = fall_cnt_q;
      conv_tmr_d = conv_tmr_q;
      tail_d = tail_q;
      dout_d = data_out_q;
      dout_en_d = data_out_en_q;
      sampling_d = sampling_q;
      holding_d = holding_q;
      power_d = converter_power_q;
      sar_start = 1'b0;
      sar_step = 1'b0;
      if (sclk_fall && fall_cnt_q != 5'h1f) begin
         fall_cnt_d = fall_cnt_q + 5'h01;
      end
      case (conv_state_q)
         C_IDLE: begin
            if (conv_cs_fall) begin
               conv_state_d = C_SAMPLE;
               fall_cnt_d = 5'h00;
               conv_tmr_d = 16'h0001;
               power_d = 1'b1;
            end
         end
         C_SAMPLE: begin
            conv_tmr_d = (conv_tmr_q == 16'hffff) ? conv_tmr_q : conv_tmr_q + 16'h0001;
            if (conv_tmr_q >= TON_CYC) begin
               sampling_d = 1'b1;
            end
            if (sclk_fall && fall_cnt_q == HOLD_CNT) begin
               // hold, start, and take the wire with a null bit
               sampling_d = 1'b0;
               holding_d = 1'b1;
               sar_start = 1'b1;
               dout_en_d = 1'b1;
               dout_d = 1'b0;
               conv_state_d = C_CONV;
            end
         end
         C_CONV: begin
            if (sclk_fall) begin
               sar_step = 1'b1;
               // each bit leaves as soon as the comparator decides it
               dout_d = comp_s;
               if (fall_cnt_q == LAST_CNT) begin
                  // twelve falling edges after hold the last bit is known
                  conv_state_d = C_TAIL;
                  power_d = 1'b0;
                  holding_d = 1'b0;
                  tail_d = {1'b0, sar_code[11:1]};
               end
            end
         end
         C_TAIL: begin
            if (sclk_fall) begin
               // lsb-first replay, then zeros once the copy empties
               dout_d = tail_q[0];
               tail_d = {1'b0, tail_q[11:1]};
            end
         end
         default: begin
            conv_state_d = C_IDLE;
         end
      endcase
      if (conv_cs_s) begin
         // select high is a reset for the converter side
         conv_state_d = C_IDLE;
         power_d = 1'b0;
         dout_en_d = 1'b0;
         dout_d = 1'b0;
         sampling_d = 1'b0;
         holding_d = 1'b0;
         conv_tmr_d = 16'h0000;
      end
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         conv_state_q <= C_IDLE;
         fall_cnt_q <= 5'h00;
         conv_tmr_q <= 16'h0000;
         tail_q <= `MXADC_CODE_RESET;
         data_out_q <= 1'b0;
         data_out_en_q <= 1'b0;
         sampling_q <= 1'b0;
         holding_q <= 1'b0;
         converter_power_q <= 1'b0;
      end else begin
         conv_state_q <= conv_state_d;
         fall_cnt_q <= fall_cnt_d;
         conv_tmr_q <= conv_tmr_d;
         tail_q <= tail_d;
         data_out_q <= dout_d;
         data_out_en_q <= dout_en_d;
         sampling_q <= sampling_d;
         holding_q <= holding_d;
         converter_power_q <= power_d;
      end
   end

   // ****************************************
   // result capture
   // ****************************************
   // the sar finishes one ref_clk after the last step, so capture then
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         result_q <= `MXADC_CODE_RESET;
         result_valid_q <= 1'b0;
      end else begin
         result_valid_q <= sar_done;
         if (sar_done) begin
            result_q <= sar_code;
         end
      end
   end
endmodule

// File: logic/mxadc_sync.v
// ****************************************
// two-stage synchroniser for pin inputs
// ****************************************
module mxadc_sync #(
   parameter WIDTH = 5,
   // idle level of each pin, so that no false edge follows reset release
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // asynchronous pins in, synchronised levels out
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_q;
         reg stable_q;
         // the first stage feeds only the second stage
         always @(posedge ref_clk) begin
            if (sys_rst) begin
               meta_q <= RST_VAL[i];
               stable_q <= RST_VAL[i];
            end else begin
               meta_q <= async_in[i];
               stable_q <= meta_q;
            end
         end
         assign sync_out[i] = stable_q;
      end
   endgenerate
endmodule
